// >>> logic/dxal_regs.sv
// Purpose: DS2 X-bit status/control, DS1 idle/loop source control, latched receive alarms
// Assumes: synchronous microprocessor strobes, one cycle each, on clk_sys
// Notes: a read of the latched alarm location clears it after the data is captured
// Contract
// R1: idle-select 1 and no loop code sends the idle pattern chosen by code bits.
// R2: idle-select 1 with loop code pending loops receive DS1 to transmit.
// R3: idle-select 0 takes transmit data and clock from the channel leads.
// R4: software ignores the reserved top bit of received X-bit status.
// R5: low seven bits of received X-bit status show current received DS2 X-bits.
// R6: software writes zero to reserved top bit of transmit X-bit control.
// R7: low seven transmit X-bit control bits are inserted as DS2 X-bits.
// R8: software normally programs transmitted X-bits to 1 for no alarm.
// R9: latched alarm bits mirror live status but latch on when alarm occurs.
// R10: bits 1 and 0 latch inverted DS3 X-bits, latched-on reads as 0.
// R11: a read returns latched values then returns all bits to off.
// R12: an alarm still present after a clearing read sets its bit again.
`timescale 1ns/1ps
`include "dxal_map.svh"
module dxal_regs #(
    parameter int NCHAN = `DXAL_NCHAN,
    parameter int NXBIT = `DXAL_NXBIT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // microprocessor bus
    input wire logic [`DXAL_ADDR_W-1:0] cpu_addr,
    input wire logic [`DXAL_DATA_W-1:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output dxal_pkg::dxal_byte_t cpu_rdata,
    output logic cpu_rvalid,
    // live status from framers
    input wire logic [NXBIT-1:0] rx_ds2_xbit,
    input wire dxal_pkg::dxal_byte_t live_rx_alarms,
    // ds2 transmit X-bits
    output logic [NXBIT-1:0] tx_ds2_xbit,
    // ds1 channel sources
    input wire logic [NCHAN-1:0] chan_tx_data_in,
    input wire logic [NCHAN-1:0] chan_tx_clock_in,
    input wire logic [NCHAN-1:0] rx_ds1_data,
    input wire logic [NCHAN-1:0] rx_ds1_clock,
    input wire logic [3:0] idle_pattern,
    output logic [NCHAN-1:0] ds1_tx_data,
    output logic [NCHAN-1:0] ds1_tx_clock,
    output logic [NCHAN-1:0] ds1_tx_is_idle
);
    import dxal_pkg::*;

    // locations served here, all others read 00 and ignore writes:
    //   02 idle code, bits 1..0
    //   11..14 idle-select banks of seven channels, bit 7 unused
    //   15 received DS2 X-bits, read only, top bit reads 0
    //   16 transmitted DS2 X-bits, top bit kept 0
    //   17 latched receive alarms, cleared by a read
    //   1E loop command, write only
    localparam int NBANK = `DXAL_IDLE_BANKS;

    dxal_src_if src_bus ();

    logic [NCHAN-1:0] chan_idle_select;
    logic [NCHAN-1:0] loop_pending;
    dxal_idle_code_t idle_code;
    dxal_byte_t tx_ds2_xbit_control;
    dxal_byte_t latched_rx_alarms;
    dxal_byte_t alarm_active;
    dxal_byte_t next_rdata;
    logic latch_read;
    logic [NCHAN-1:0] next_idle_select;

    // the selector sees the channel controls only through the interface
    assign src_bus.chan_idle_select = chan_idle_select;
    assign src_bus.loop_pending = loop_pending;
    assign src_bus.idle_code = idle_code;

    // idle select bits spread over banks of 7 channels at consecutive offsets
    always_comb begin
        next_idle_select = chan_idle_select;
        for (int b = 0; b < NBANK; b++) begin
            for (int i = 0; i < NXBIT; i++) begin
                if (cpu_wr && cpu_addr == `DXAL_OFF_IDLE0 + (`DXAL_ADDR_W)'(b)
                    && b * NXBIT + i < NCHAN) begin
                    next_idle_select[b * NXBIT + i] = cpu_wdata[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_idle_select <= '0;
        end else begin
            chan_idle_select <= next_idle_select;
        end
    end

    // loopback command: bit 7 connects, low bits name the channel
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loop_pending <= '0;
        end else if (cpu_wr && cpu_addr == `DXAL_OFF_LOOP) begin
            for (int c = 0; c < NCHAN; c++) begin
                if (cpu_wdata[4:0] == 5'(c)) begin
                    loop_pending[c] <= cpu_wdata[7];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idle_code <= '0;
        end else if (cpu_wr && cpu_addr == `DXAL_OFF_CTRL) begin
            idle_code <= {cpu_wdata[`DXAL_IDLE_CODE_SEL_HI_BIT], cpu_wdata[`DXAL_IDLE_CODE_SEL_LO_BIT]};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_ds2_xbit_control <= `DXAL_TXX_RESET;
        end else if (cpu_wr && cpu_addr == `DXAL_OFF_TXX) begin
            // reserved top bit is held at 0 whatever software writes
            tx_ds2_xbit_control <= {1'b0, cpu_wdata[NXBIT-1:0]}; // [R6]
        end
    end

    // all ones from reset, so the far end sees X-bits off until software writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_ds2_xbit <= '1;
        end else begin
            tx_ds2_xbit <= tx_ds2_xbit_control[NXBIT-1:0]; // [R7] [R8]
        end
    end

    // alarm condition per bit: bits 1..0 active when received X-bit is 0
    always_comb begin
        alarm_active = live_rx_alarms ^ `DXAL_LATCH_OFF; // [R10]
    end

    assign latch_read = cpu_rd && cpu_addr == `DXAL_OFF_LATCH;

    // per alarm bit, active high inside: a read clears, a present alarm sets,
    // and the set wins so an alarm in the read cycle is not lost
    localparam dxal_byte_t OFF_MASK = `DXAL_LATCH_OFF;
    genvar ga;
    generate
        for (ga = 0; ga < `DXAL_DATA_W; ga++) begin : gen_alarm
            logic held;
            logic next_bit;
            assign held = (latched_rx_alarms[ga] ^ OFF_MASK[ga]) && !latch_read; // [R11]
            assign next_bit = held || alarm_active[ga]; // [R9] [R12]
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    latched_rx_alarms[ga] <= OFF_MASK[ga];
                end else begin
                    // bits 1..0 are kept inverted, so latched on reads 0
                    latched_rx_alarms[ga] <= next_bit ^ OFF_MASK[ga]; // [R10]
                end
            end
        end
    endgenerate

    // read image of each idle-select bank; positions past the last channel read 0
    logic [NBANK-1:0][`DXAL_DATA_W-1:0] bank_image;
    genvar gb;
    genvar gi;
    generate
        for (gb = 0; gb < NBANK; gb++) begin : gen_bank
            for (gi = 0; gi < `DXAL_DATA_W; gi++) begin : gen_pos
                if (gi < NXBIT && gb * NXBIT + gi < NCHAN) begin : gen_used
                    assign bank_image[gb][gi] = chan_idle_select[gb * NXBIT + gi];
                end else begin : gen_spare
                    assign bank_image[gb][gi] = 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        case (cpu_addr)
            `DXAL_OFF_RXX: next_rdata = {1'b0, rx_ds2_xbit}; // [R5] [R4]
            `DXAL_OFF_TXX: next_rdata = tx_ds2_xbit_control;
            `DXAL_OFF_LATCH: next_rdata = latched_rx_alarms; // [R11]
            `DXAL_OFF_CTRL: next_rdata = {6'h00, idle_code};
            default: next_rdata = 8'h00;
        endcase
        for (int b = 0; b < NBANK; b++) begin
            if (cpu_addr == `DXAL_OFF_IDLE0 + (`DXAL_ADDR_W)'(b)) begin
                next_rdata = bank_image[b];
            end
        end
    end

    // read data stays until the next read, so a slow host may take it late
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cpu_rdata <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_rd;
            if (cpu_rd) begin
                cpu_rdata <= next_rdata;
            end
        end
    end

    // source selection per channel, registered inside the selector
    dxal_chan_sel #(
        .NCHAN(NCHAN)
    ) u_sel (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ctl(src_bus.sel),
        .chan_tx_data_in(chan_tx_data_in),
        .chan_tx_clock_in(chan_tx_clock_in),
        .rx_ds1_data(rx_ds1_data),
        .rx_ds1_clock(rx_ds1_clock),
        .idle_pattern(idle_pattern),
        .ds1_tx_data(ds1_tx_data),
        .ds1_tx_clock(ds1_tx_clock),
        .ds1_tx_is_idle(ds1_tx_is_idle)
    );
endmodule

// >>> logic/dxal_map.svh
// Purpose: register offsets, field positions, reset values of the X-bit/alarm latch slice
// Assumes: 8-bit microprocessor data, 6-bit address space of 64 locations
// Notes: offsets are byte locations on the microprocessor bus
`ifndef DXAL_MAP_SVH
`define DXAL_MAP_SVH
`define DXAL_ADDR_W 6
`define DXAL_DATA_W 8
`define DXAL_NCHAN 28
`define DXAL_NXBIT 7
`define DXAL_IDLE_BANKS 4
`define DXAL_OFF_CTRL 6'h02
`define DXAL_OFF_IDLE0 6'h11
`define DXAL_OFF_RXX 6'h15
`define DXAL_OFF_TXX 6'h16
`define DXAL_OFF_LATCH 6'h17
`define DXAL_OFF_LOOP 6'h1E
`define DXAL_IDLE_CODE_SEL_HI_BIT 1
`define DXAL_IDLE_CODE_SEL_LO_BIT 0
`define DXAL_TXX_RESET 8'h7F
`define DXAL_LATCH_OFF 8'h03
`define DXAL_RESERVED_TOP 7
`endif

// >>> logic/dxal_pkg.sv
// Purpose: types shared by the X-bit/alarm latch slice
// Assumes: nothing beyond the map header
// Notes: source selection per DS1 channel
package dxal_pkg;
    typedef enum {
        DXAL_SRC_LEADS,
        DXAL_SRC_IDLE,
        DXAL_SRC_LOOP
    } dxal_src_t;
    typedef logic [7:0] dxal_byte_t;
    typedef logic [1:0] dxal_idle_code_t;
endpackage

// >>> logic/dxal_src_if.sv
// Purpose: carries per-channel source controls between the register bank and the selector
// Assumes: one clock domain
// Notes: bank drives, selector listens
`timescale 1ns/1ps
`include "dxal_map.svh"
interface dxal_src_if;
    logic [`DXAL_NCHAN-1:0] chan_idle_select;
    logic [`DXAL_NCHAN-1:0] loop_pending;
    logic [1:0] idle_code;
    modport bank (output chan_idle_select, output loop_pending, output idle_code);
    modport sel (input chan_idle_select, input loop_pending, input idle_code);
endinterface

// >>> logic/dxal_chan_sel.sv
// Purpose: per-channel DS1 transmit source selection and registered outputs
// Assumes: loopback data and transmit leads are synchronous to clk_sys
// Notes: idle pattern bits are supplied by the idle generator outside
`timescale 1ns/1ps
`include "dxal_map.svh"
module dxal_chan_sel #(
    parameter int NCHAN = `DXAL_NCHAN
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // controls
    dxal_src_if.sel ctl,
    // data sources
    input wire logic [NCHAN-1:0] chan_tx_data_in,
    input wire logic [NCHAN-1:0] chan_tx_clock_in,
    input wire logic [NCHAN-1:0] rx_ds1_data,
    input wire logic [NCHAN-1:0] rx_ds1_clock,
    input wire logic [3:0] idle_pattern,
    // selected stream
    output logic [NCHAN-1:0] ds1_tx_data,
    output logic [NCHAN-1:0] ds1_tx_clock,
    output logic [NCHAN-1:0] ds1_tx_is_idle
);
    import dxal_pkg::*;
    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : gen_chan
            dxal_src_t src;
            always_comb begin
                if (!ctl.chan_idle_select[g]) begin
                    src = DXAL_SRC_LEADS; // [R3]
                end else if (ctl.loop_pending[g]) begin
                    src = DXAL_SRC_LOOP; // [R2]
                end else begin
                    src = DXAL_SRC_IDLE; // [R1]
                end
            end
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    ds1_tx_data[g] <= 1'b0;
                    ds1_tx_clock[g] <= 1'b0;
                    ds1_tx_is_idle[g] <= 1'b0;
                end else begin
                    case (src)
                        DXAL_SRC_LEADS: begin
                            ds1_tx_data[g] <= chan_tx_data_in[g];
                            ds1_tx_clock[g] <= chan_tx_clock_in[g];
                            ds1_tx_is_idle[g] <= 1'b0;
                        end
                        DXAL_SRC_LOOP: begin
                            ds1_tx_data[g] <= rx_ds1_data[g];
                            ds1_tx_clock[g] <= rx_ds1_clock[g];
                            ds1_tx_is_idle[g] <= 1'b0;
                        end
                        DXAL_SRC_IDLE: begin
                            ds1_tx_data[g] <= idle_pattern[ctl.idle_code];
                            ds1_tx_clock[g] <= chan_tx_clock_in[g];
                            ds1_tx_is_idle[g] <= 1'b1;
                        end
                        default: begin
                            ds1_tx_data[g] <= 1'b0;
                            ds1_tx_clock[g] <= 1'b0;
                            ds1_tx_is_idle[g] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate
endmodule

// >>> tb/dxal_regs_props.sv
// Purpose: port assertions for the X-bit/alarm register slice
// Assumes: one clock, async active-low reset
// Notes: bound to every dxal_regs
`timescale 1ns/1ps
`include "dxal_map.svh"
module dxal_regs_props #(
    parameter int NCHAN = 28,
    parameter int NXBIT = 7
) (
    // clock, reset, bus
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [5:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire dxal_pkg::dxal_byte_t cpu_rdata,
    input wire logic cpu_rvalid,
    // status and control
    input wire logic [NXBIT-1:0] rx_ds2_xbit,
    input wire dxal_pkg::dxal_byte_t live_rx_alarms,
    input wire logic [NXBIT-1:0] tx_ds2_xbit
);
    import dxal_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // alarms in active-high form
    wire logic [7:0] alm = live_rx_alarms ^ 8'h03;
    wire logic rl = cpu_rd && cpu_addr == `DXAL_OFF_LATCH;
    wire logic wt = cpu_wr && cpu_addr == `DXAL_OFF_TXX;
    AST_RVALID: assert property (cpu_rd |=> cpu_rvalid)
        else $error("read gave no valid");
    AST_NOVALID: assert property (!cpu_rd |=> !cpu_rvalid)
        else $error("valid without read");
    AST_RDHOLD: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data moved");
    AST_RXX: assert property (cpu_rd && cpu_addr == `DXAL_OFF_RXX
        |=> cpu_rdata == {1'b0, $past(rx_ds2_xbit)}) else $error("rx xbit wrong");
    AST_TXX: assert property (wt ##1 !wt |=> tx_ds2_xbit == $past(cpu_wdata[NXBIT-1:0], 2))
        else $error("tx xbit wrong");
    AST_TXHOLD: assert property (!wt [*2] |=> $stable(tx_ds2_xbit))
        else $error("tx xbit moved");
    AST_LATCH: assert property (rl && $past(resetn)
        |=> ((cpu_rdata ^ 8'h03) & $past(alm, 2)) == $past(alm, 2)) else $error("alarm lost");
    AST_CLEAR: assert property (rl && alm == 8'h00 ##1 rl |=> cpu_rdata == 8'h03)
        else $error("latch not cleared");
    AST_UNMAP: assert property (cpu_rd && cpu_addr == 6'h3F |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind dxal_regs dxal_regs_props #(.NCHAN(NCHAN), .NXBIT(NXBIT)) dxal_regs_props_inst (
    .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .rx_ds2_xbit(rx_ds2_xbit), .live_rx_alarms(live_rx_alarms), .tx_ds2_xbit(tx_ds2_xbit)
);

// >>> tb/dxal_regs_tb_top.sv
// Purpose: self-checking bench for the X-bit/alarm register slice
// Assumes: strobes driven 5 ns after the rising edge
// Notes: monitor models every read result
`timescale 1ns/1ps
`include "dxal_map.svh"
module dxal_regs_tb_top;
    import dxal_pkg::*;
    logic clk_sys = 0;
    logic resetn = 0;
    logic [5:0] cpu_addr = 0;
    logic [7:0] cpu_wdata = 0;
    logic cpu_wr = 0;
    logic cpu_rd = 0;
    dxal_byte_t cpu_rdata;
    logic cpu_rvalid;
    logic [6:0] rx_ds2_xbit = 0;
    logic [6:0] tx_ds2_xbit;
    dxal_byte_t live = 8'h03;
    logic [27:0] tdat = 0, tclk = 0, rdat = 0, rclk = 0, odat, oclk, oidl;
    logic [3:0] idle_pattern = 0;
    logic [31:0] seed = 32'h2B64;
    logic [7:0] d;
    int fail_count = 0, n_checks = 0, txx_m = 'h7F, lat_m = 0, pend = 0, pend_v = 0;
    int ctrl_m = 0, bank = 0;
    int idl_m[4] = '{0, 0, 0, 0};
    dxal_regs dxal_regs_inst (
        .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .rx_ds2_xbit(rx_ds2_xbit), .live_rx_alarms(live), .tx_ds2_xbit(tx_ds2_xbit),
        .chan_tx_data_in(tdat), .chan_tx_clock_in(tclk), .rx_ds1_data(rdat),
        .rx_ds1_clock(rclk), .idle_pattern(idle_pattern), .ds1_tx_data(odat),
        .ds1_tx_clock(oclk), .ds1_tx_is_idle(oidl)
    );
    always #25 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read results: {valid, data}
    task automatic chk_rd(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1;
        @(posedge clk_sys);
        #5 cpu_wr = 0;
        repeat (3) @(posedge clk_sys);
        #5;
    endtask
    task automatic rd(input logic [5:0] a, input int n);
        cpu_addr = a;
        cpu_rd = 1;
        repeat (n) @(posedge clk_sys);
        #5 cpu_rd = 0;
        @(posedge clk_sys);
        #5;
    endtask
    // reference model: checks the answer of each read one edge after it
    always @(posedge clk_sys) begin
        if (!resetn) begin
            txx_m = 'h7F;
            lat_m = 0;
            pend = 0;
            ctrl_m = 0;
            idl_m = '{0, 0, 0, 0};
        end else begin
            if (pend) chk_rd({cpu_rvalid, cpu_rdata}, 9'(pend_v));
            pend = cpu_rd;
            bank = int'(cpu_addr) - int'(`DXAL_OFF_IDLE0);
            case (cpu_addr)
                `DXAL_OFF_RXX: pend_v = 'h100 | rx_ds2_xbit;
                `DXAL_OFF_TXX: pend_v = 'h100 | txx_m;
                `DXAL_OFF_LATCH: pend_v = 'h100 | (lat_m ^ 3);
                `DXAL_OFF_CTRL: pend_v = 'h100 | ctrl_m;
                default: pend_v = (bank >= 0 && bank < 4) ? 'h100 | idl_m[bank] : 'h100;
            endcase
            if (cpu_wr && cpu_addr == `DXAL_OFF_CTRL) ctrl_m = cpu_wdata & 3;
            if (cpu_wr && bank >= 0 && bank < 4) idl_m[bank] = cpu_wdata & 'h7F;
            if (cpu_rd && cpu_addr == `DXAL_OFF_LATCH) lat_m = live ^ 3;
            else lat_m |= live ^ 3;
            if (cpu_wr && cpu_addr == `DXAL_OFF_TXX) txx_m = cpu_wdata & 'h7F;
        end
    end
    initial begin
        #100000 fail_count++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        #5 resetn = 1;
        chk(28'(tx_ds2_xbit), 28'h7F);
        rd(`DXAL_OFF_LATCH, 1);
        for (int i = 0; i < 4; i++) begin
            rx_ds2_xbit = 7'(rnd());
            rd(`DXAL_OFF_RXX, 1);
            d = 8'(rnd()) & 8'h7F;
            wr(`DXAL_OFF_TXX, d);
            chk(28'(tx_ds2_xbit), 28'(d));
            rd(`DXAL_OFF_TXX, 1);
        end
        wr(`DXAL_OFF_TXX, 8'h7F);
        for (int k = 0; k < 8; k++) begin
            live = 8'h03 ^ (8'h01 << k);
            @(posedge clk_sys);
            #5 live = 8'h03;
            rd(`DXAL_OFF_LATCH, 2);
        end
        live = 8'h81;
        rd(`DXAL_OFF_LATCH, 2);
        live = 8'h03;
        rd(`DXAL_OFF_LATCH, 1);
        rd(6'h3F, 1);
        wr(6'h3F, 8'h00);
        rd(`DXAL_OFF_TXX, 1);
        {tdat, tclk} = 56'({rnd(), rnd()});
        {rdat, rclk, idle_pattern} = 60'({rnd(), rnd()});
        for (int b = 0; b < 4; b++) wr(6'(`DXAL_OFF_IDLE0 + b), 8'h00);
        rd(`DXAL_OFF_IDLE0 + 6'h3, 1);
        chk(odat, tdat);
        chk(oclk, tclk);
        wr(`DXAL_OFF_IDLE0, 8'hFF);
        rd(`DXAL_OFF_IDLE0, 1);
        for (int c = 0; c < 4; c++) begin
            wr(`DXAL_OFF_CTRL, 8'(c));
            rd(`DXAL_OFF_CTRL, 1);
            chk(odat, {tdat[27:7], {7{idle_pattern[c]}}});
            chk(oidl, 28'h7F);
        end
        wr(`DXAL_OFF_LOOP, 8'h80);
        chk(28'({odat[0], oclk[0]}), 28'({rdat[0], rclk[0]}));
        wr(`DXAL_OFF_LOOP, 8'h00);
        chk(28'(odat[0]), 28'(idle_pattern[3]));
        complete_run();
    end
endmodule
